// [rtl/mdtm_pkg.sv]
// Constants and types of the motor drive trip monitor
// How it works
// - Armature overvolts: >120% max for 1.5s
// - Overvolts check ignores feedback source choice
// - Field overcurrent: >115% rated for 15s
// - Field loss trips after 2s sustained
// - User trip input high 0.5s trips
// - Thermistor above 1800 ohms 15s trips
// - Thermistor trip clears by restart once cool
// - Thermistor trip cannot be disabled
// - Thermistor warning flag, cleared by start/jog
// - Overspeed >110% for 0.5s plus delay
// - Field weakening on armature feedback: mismatch trip
// - Supply loss: 2s ride-through, then contactor off
// - Current demand off during supply loss
// - Start without supply: contactor briefly, no current
// - Phase loss trips after 2.0s sustained
// - Lock time 0.75s delays contactor at start
// - Sync loss 0.5s running; start failure lockout
// - Heatsink open 0.75s trips; restart needs closed
// - Reference exchange warning, cleared by start/jog
// - Autotune: field off, error on speed/field
// - Autotune quit on inputs, disable, 2min timeout
// - Overspeed delay 0.1 to 600.0s, default 5.0
// - Restart clears trip when external reset enabled
package mdtm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int AOV_DELAY_MS = 1500;
  localparam int FOC_DELAY_MS = 15000;
  localparam int FLOSS_DELAY_MS = 2000;
  localparam int USER_DELAY_MS = 500;
  localparam int THERM_DELAY_MS = 15000;
  localparam int OVSPD_BASE_MS = 500;
  localparam int OVSPD_STEP_MS = 100;
  localparam int SPDMIS_DELAY_MS = 1;
  localparam int PHASE_DELAY_MS = 2000;
  localparam int SYNC_DELAY_MS = 500;
  localparam int HEAT_DELAY_MS = 750;
  localparam int REFX_DELAY_MS = 1500;
  localparam int RIDE_MS = 2000;
  localparam int NOSUP_MS = 3000;
  localparam int LOCK_MS = 750;
  localparam int AT_TIMEOUT_MS = 120000;

  // ----------------------------------------------------------------
  // Thresholds as ratios
  // ----------------------------------------------------------------
  localparam logic [23:0] AOV_NUM = 24'h000006;
  localparam logic [23:0] AOV_DEN = 24'h000005;
  localparam logic [23:0] FOC_NUM = 24'h000073;
  localparam logic [23:0] FOC_DEN = 24'h000064;
  localparam logic [23:0] OVS_NUM = 24'h00000b;
  localparam logic [23:0] OVS_DEN = 24'h00000a;
  localparam logic [23:0] AT_SPD_DEN = 24'h000005;
  localparam logic [23:0] AT_FLD_DEN = 24'h000014;
  localparam logic [15:0] THERM_OHMS = 16'h0708;
  localparam logic [12:0] OVD_MIN = 13'h0001;
  localparam logic [12:0] OVD_MAX = 13'h1770;
  localparam logic [12:0] OVD_RESET = 13'h0032;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OVD = 8'h04;
  localparam logic [7:0] REG_VMAX = 8'h08;
  localparam logic [7:0] REG_FLD_RATED = 8'h0c;
  localparam logic [7:0] REG_SPD_RATED = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_ACTIVE = 8'h18;
  localparam int CTRL_EXT_RESET_BIT = 0;
  localparam int CTRL_AT_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [15:0] RATED_RESET = 16'hffff;

  // ----------------------------------------------------------------
  // Alarm indices; the index is also the latched trip code
  // ----------------------------------------------------------------
  localparam int NUM_ALARM = 11;
  localparam int AL_AOV = 0;
  localparam int AL_FOC = 1;
  localparam int AL_FLOSS = 2;
  localparam int AL_USER = 3;
  localparam int AL_THERM = 4;
  localparam int AL_OVSPD = 5;
  localparam int AL_SPDMIS = 6;
  localparam int AL_PHASE = 7;
  localparam int AL_SYNC = 8;
  localparam int AL_HEAT = 9;
  localparam int AL_REFX = 10;
  localparam logic [3:0] CODE_LOCKOUT = 4'hb;
  localparam logic [10:0] TRIP_MASK = 11'h3ff;

  typedef enum logic [2:0] {
    MDTM_IDLE = 3'b000,
    MDTM_LOCKWAIT = 3'b001,
    MDTM_RUN = 3'b010,
    MDTM_RIDE = 3'b011,
    MDTM_NOSUP = 3'b100
  } mdtm_seq_t;

endpackage

// [rtl/mdtm_trip_monitor.sv]
// Top module of the motor drive trip monitor
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mdtm_trip_monitor #(
  parameter int TICK_DIV = mdtm_pkg::TICK_CYCLES // Clocks per 1 ms tick
) (
  input wire logic CORE_CLK, // 250 MHz clock
  input wire logic RESET, // Synchronous reset, high
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write
  input wire logic [7:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte lanes
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  input wire logic [15:0] ARM_VOLT_FB, // Armature voltage feedback
  input wire logic [15:0] FIELD_CUR_FB, // Field current feedback
  input wire logic [15:0] SPEED_FB, // Speed feedback
  input wire logic [15:0] THERM_OHMS_FB, // Sensor loop resistance, ohms
  input wire logic FIELD_LOSS, // Field loss detected
  input wire logic USER_TRIP, // User trip request
  input wire logic HEATSINK_CLOSED, // Heatsink switch closed
  input wire logic SUPPLY_SENSE_A, // Supply phase A present
  input wire logic SUPPLY_SENSE_B, // Supply phase B present
  input wire logic SYNC_LOCK, // Phase lock achieved
  input wire logic ARMATURE_VOLTAGE_SPEED_FEEDBACK, // Armature fb used
  input wire logic FIELD_WEAKEN, // Field weakening attempted
  input wire logic REFX_BAD, // Bad reference exchange
  input wire logic START, // Start command level
  input wire logic JOG, // Jog command level
  input wire logic RUN, // Run terminal level
  input wire logic COAST_STOP, // Coast stop terminal, high is ok
  output logic CONTACTOR, // Main contactor energise
  output logic CURRENT_EN, // Armature current enable
  output logic FIELD_EN, // Field enable
  output logic TRIP, // Drive tripped
  output logic [3:0] TRIP_CODE, // First alarm identity
  output logic THERM_WARN, // Thermistor warning
  output logic REFX_WARN, // Reference exchange warning
  output logic AT_ERROR, // Autotune error
  output logic AT_QUIT // Autotune quit
);
  import mdtm_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [17:0] pre_q;
  logic tick_q;
  logic start_q;
  logic jog_q;
  logic start_rise;
  logic jog_rise;
  logic [1:0] ctrl_q;
  logic [12:0] ovd_q;
  logic [15:0] vmax_q;
  logic [15:0] fld_rated_q;
  logic [15:0] spd_rated_q;
  logic wb_req;
  logic [NUM_ALARM-1:0] cond;
  logic [NUM_ALARM-1:0] expd;
  logic [19:0] lim [NUM_ALARM];
  logic supply_ok;
  mdtm_seq_t seq_q;
  mdtm_seq_t seq_d;
  logic [19:0] seq_cnt_q;
  logic seq_restart;
  logic lockout;
  logic trip_q;
  logic [3:0] code_q;
  logic new_trip;
  logic [3:0] new_code;
  logic trip_clear;
  logic therm_warn_q;
  logic refx_warn_q;
  logic at_run_q;
  logic [16:0] at_cnt_q;
  logic at_err_q;
  logic at_quit_q;
  logic at_bad;
  logic at_stop;
  logic [23:0] av_x;
  logic [23:0] fi_x;
  logic [23:0] sp_x;

  // ----------------------------------------------------------------
  // Millisecond tick; the divider is a parameter so benches can shrink it
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET || pre_q == 18'(TICK_DIV - 1)) begin
      pre_q <= 18'h00000;
    end else begin
      pre_q <= pre_q + 18'h00001;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == 18'(TICK_DIV - 1));
    end
  end

  // Command edges: start and jog act on their rising edge
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      start_q <= 1'b0;
      jog_q <= 1'b0;
    end else begin
      start_q <= START;
      jog_q <= JOG;
    end
  end
  assign start_rise = START & ~start_q;
  assign jog_rise = JOG & ~jog_q;

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  // Writes land in the cycle the acknowledge is raised
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_q <= CTRL_RESET;
      ovd_q <= OVD_RESET;
      vmax_q <= RATED_RESET;
      fld_rated_q <= RATED_RESET;
      spd_rated_q <= RATED_RESET;
    end else if (wb_req && WB_WE_I) begin
      if (WB_ADR_I == REG_CTRL) begin
        if (WB_SEL_I[0]) begin
          ctrl_q <= WB_DAT_I[1:0];
        end
      end else if (WB_ADR_I == REG_OVD) begin
        // Out-of-range delays are clamped, never stored raw
        if (WB_SEL_I[1:0] == 2'h3) begin
          if (WB_DAT_I[15:0] < 16'(OVD_MIN)) begin
            ovd_q <= OVD_MIN;
          end else if (WB_DAT_I[15:0] > 16'(OVD_MAX)) begin
            ovd_q <= OVD_MAX;
          end else begin
            ovd_q <= WB_DAT_I[12:0];
          end
        end
      end else if (WB_ADR_I == REG_VMAX) begin
        if (WB_SEL_I[1:0] == 2'h3) begin
          vmax_q <= WB_DAT_I[15:0];
        end
      end else if (WB_ADR_I == REG_FLD_RATED) begin
        if (WB_SEL_I[1:0] == 2'h3) begin
          fld_rated_q <= WB_DAT_I[15:0];
        end
      end else if (WB_ADR_I == REG_SPD_RATED) begin
        if (WB_SEL_I[1:0] == 2'h3) begin
          spd_rated_q <= WB_DAT_I[15:0];
        end
      end
    end
  end

  // Read mux, registered with the acknowledge
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WB_DAT_O <= 32'h00000000;
    end else if (wb_req && !WB_WE_I) begin
      if (WB_ADR_I == REG_CTRL) begin
        WB_DAT_O <= {30'h00000000, ctrl_q};
      end else if (WB_ADR_I == REG_OVD) begin
        WB_DAT_O <= {19'h00000, ovd_q};
      end else if (WB_ADR_I == REG_VMAX) begin
        WB_DAT_O <= {16'h0000, vmax_q};
      end else if (WB_ADR_I == REG_FLD_RATED) begin
        WB_DAT_O <= {16'h0000, fld_rated_q};
      end else if (WB_ADR_I == REG_SPD_RATED) begin
        WB_DAT_O <= {16'h0000, spd_rated_q};
      end else if (WB_ADR_I == REG_STATUS) begin
        WB_DAT_O <= {20'h00000, seq_q, at_quit_q, at_err_q,
                     refx_warn_q, therm_warn_q, code_q, trip_q};
      end else if (WB_ADR_I == REG_ACTIVE) begin
        WB_DAT_O <= {21'h000000, expd};
      end else begin
        WB_DAT_O <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault conditions; ratios compared by cross-multiplying
  // ----------------------------------------------------------------
  assign av_x = {8'h00, ARM_VOLT_FB};
  assign fi_x = {8'h00, FIELD_CUR_FB};
  assign sp_x = {8'h00, SPEED_FB};
  assign supply_ok = SUPPLY_SENSE_A & SUPPLY_SENSE_B;

  // Overvolts uses the voltage itself, whatever feeds the speed loop
  assign cond[AL_AOV] = av_x * AOV_DEN > {8'h00, vmax_q} * AOV_NUM;
  assign cond[AL_FOC] = fi_x * FOC_DEN > {8'h00, fld_rated_q} * FOC_NUM;
  assign cond[AL_FLOSS] = FIELD_LOSS;
  assign cond[AL_USER] = USER_TRIP;
  // No inhibit exists here: an unused sensor loop must be linked
  assign cond[AL_THERM] = THERM_OHMS_FB > THERM_OHMS;
  assign cond[AL_OVSPD] = sp_x * OVS_DEN > {8'h00, spd_rated_q} * OVS_NUM;
  assign cond[AL_SPDMIS] = FIELD_WEAKEN & ARMATURE_VOLTAGE_SPEED_FEEDBACK;
  // Loss only matters in run or ride-through; in NOSUP the contactor is in but loss is ignored
  assign cond[AL_PHASE] = ~supply_ok &
                          (seq_q == MDTM_RUN || seq_q == MDTM_RIDE);
  assign cond[AL_SYNC] = ~SYNC_LOCK & (seq_q == MDTM_RUN);
  assign cond[AL_HEAT] = ~HEATSINK_CLOSED;
  assign cond[AL_REFX] = REFX_BAD;

  // Per-alarm delay limits in ticks
  always_comb begin
    lim[AL_AOV] = 20'(AOV_DELAY_MS);
    lim[AL_FOC] = 20'(FOC_DELAY_MS);
    lim[AL_FLOSS] = 20'(FLOSS_DELAY_MS);
    lim[AL_USER] = 20'(USER_DELAY_MS);
    lim[AL_THERM] = 20'(THERM_DELAY_MS);
    lim[AL_OVSPD] = 20'(OVSPD_BASE_MS) + 20'(ovd_q) * 20'(OVSPD_STEP_MS);
    lim[AL_SPDMIS] = 20'(SPDMIS_DELAY_MS);
    lim[AL_PHASE] = 20'(PHASE_DELAY_MS);
    lim[AL_SYNC] = 20'(SYNC_DELAY_MS);
    lim[AL_HEAT] = 20'(HEAT_DELAY_MS);
    lim[AL_REFX] = 20'(REFX_DELAY_MS);
  end

  // ----------------------------------------------------------------
  // Alarm delay timers, one per alarm
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_ALARM; g++) begin : g_alarm
    logic [19:0] cnt_q;
    // A condition that drops early throws the elapsed time away
    always_ff @(posedge CORE_CLK) begin
      if (RESET || !cond[g]) begin
        cnt_q <= 20'h00000;
        expd[g] <= 1'b0;
      end else if (tick_q && !expd[g]) begin
        cnt_q <= cnt_q + 20'h00001;
        expd[g] <= (cnt_q + 20'h00001 >= lim[g]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Supply, lock and contactor sequencing
  // ----------------------------------------------------------------
  always_comb begin
    seq_d = seq_q;
    seq_restart = 1'b0;
    lockout = 1'b0;
    if (trip_q || new_trip) begin
      seq_d = MDTM_IDLE;
    end else begin
      case (seq_q)
        MDTM_IDLE: begin
          if (start_rise) begin
            seq_restart = 1'b1;
            if (!supply_ok) begin
              seq_d = MDTM_NOSUP;
            end else if (!SYNC_LOCK) begin
              seq_d = MDTM_LOCKWAIT;
            end else begin
              seq_d = MDTM_RUN;
            end
          end
        end
        MDTM_LOCKWAIT: begin
          // Contactor waits for lock; no lock in time is a lockout
          if (!START) begin
            seq_d = MDTM_IDLE;
          end else if (SYNC_LOCK) begin
            seq_d = MDTM_RUN;
          end else if (seq_cnt_q >= 20'(LOCK_MS)) begin
            lockout = 1'b1;
          end
        end
        MDTM_RUN: begin
          if (!START) begin
            seq_d = MDTM_IDLE;
          end else if (!supply_ok) begin
            seq_restart = 1'b1;
            seq_d = MDTM_RIDE;
          end
        end
        MDTM_RIDE: begin
          if (supply_ok) begin
            seq_d = MDTM_RUN;
          end else if (seq_cnt_q >= 20'(RIDE_MS) || !START) begin
            seq_d = MDTM_IDLE;
          end
        end
        MDTM_NOSUP: begin
          if (seq_cnt_q >= 20'(NOSUP_MS)) begin
            seq_d = MDTM_IDLE;
          end
        end
        default: begin
          seq_d = MDTM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      seq_q <= MDTM_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // Shared sequencer timer, counted in ticks
  always_ff @(posedge CORE_CLK) begin
    if (RESET || seq_restart) begin
      seq_cnt_q <= 20'h00000;
    end else if (tick_q && seq_cnt_q != 20'hfffff) begin
      seq_cnt_q <= seq_cnt_q + 20'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Trip latch: lowest alarm index wins when several expire together
  // ----------------------------------------------------------------
  always_comb begin
    new_trip = lockout;
    new_code = CODE_LOCKOUT;
    for (int i = NUM_ALARM - 1; i >= 0; i--) begin
      if (expd[i] && TRIP_MASK[i]) begin
        new_trip = 1'b1;
        new_code = 4'(i);
      end
    end
  end

  // Restart clears only when the sensors read healthy again
  assign trip_clear = start_rise & ctrl_q[CTRL_EXT_RESET_BIT] &
                      ~cond[AL_THERM] & ~cond[AL_HEAT];

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      trip_q <= 1'b0;
      code_q <= 4'h0;
    end else if (!trip_q && new_trip) begin
      trip_q <= 1'b1;
      code_q <= new_code;
    end else if (trip_q && trip_clear && !new_trip) begin
      trip_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Warning flags; a fresh expiry beats a start or jog clear
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      therm_warn_q <= 1'b0;
    end else if (expd[AL_THERM]) begin
      therm_warn_q <= 1'b1;
    end else if (start_rise || jog_rise) begin
      therm_warn_q <= 1'b0;
    end
  end

  // Reported even though this alarm never trips the drive
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      refx_warn_q <= 1'b0;
    end else if (expd[AL_REFX]) begin
      refx_warn_q <= 1'b1;
    end else if (start_rise || jog_rise) begin
      refx_warn_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Autotune supervision
  // ----------------------------------------------------------------
  assign at_bad = (sp_x * AT_SPD_DEN > {8'h00, spd_rated_q}) ||
                  (fi_x * AT_FLD_DEN > {8'h00, fld_rated_q});
  assign at_stop = ~COAST_STOP | ~START | ~RUN |
                   ~ctrl_q[CTRL_AT_EN_BIT] |
                   (at_cnt_q >= 17'(AT_TIMEOUT_MS));

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      at_run_q <= 1'b0;
      at_err_q <= 1'b0;
      at_quit_q <= 1'b0;
    end else if (!at_run_q) begin
      if (start_rise && ctrl_q[CTRL_AT_EN_BIT] && !trip_q) begin
        at_run_q <= 1'b1;
        at_err_q <= 1'b0;
        at_quit_q <= 1'b0;
      end
    end else if (at_bad) begin
      at_run_q <= 1'b0;
      at_err_q <= 1'b1;
    end else if (at_stop || trip_q) begin
      at_run_q <= 1'b0;
      at_quit_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || !at_run_q) begin
      at_cnt_q <= 17'h00000;
    end else if (tick_q) begin
      at_cnt_q <= at_cnt_q + 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs, one clock behind the state they reflect
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CONTACTOR <= 1'b0;
      CURRENT_EN <= 1'b0;
      FIELD_EN <= 1'b0;
    end else begin
      CONTACTOR <= ~trip_q & (seq_q == MDTM_RUN || seq_q == MDTM_RIDE ||
                              seq_q == MDTM_NOSUP);
      // Current stays off without supply; restart into a spinning load
      CURRENT_EN <= ~trip_q & (seq_q == MDTM_RUN) & supply_ok;
      FIELD_EN <= ~trip_q & ~at_run_q & (seq_q == MDTM_RUN);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TRIP <= 1'b0;
      TRIP_CODE <= 4'h0;
      THERM_WARN <= 1'b0;
      REFX_WARN <= 1'b0;
      AT_ERROR <= 1'b0;
      AT_QUIT <= 1'b0;
    end else begin
      TRIP <= trip_q;
      TRIP_CODE <= code_q;
      THERM_WARN <= therm_warn_q;
      REFX_WARN <= refx_warn_q;
      AT_ERROR <= at_err_q;
      AT_QUIT <= at_quit_q;
    end
  end

endmodule
`default_nettype wire

// [testbench/mdtm_sensor_model.sv]
// Supply and phase lock model for the trip monitor bench
`timescale 1ns/1ns
`default_nettype none
module mdtm_sensor_model #(
  parameter int LOCK_CYC = 8 // Clocks to regain lock
) (
  input wire logic clk, // Clock
  input wire logic supply_on, // Mains present
  output logic sense_a, // Phase A
  output logic sense_b, // Phase B
  output logic lock // Phase lock
);
  logic [7:0] cnt_q = 8'h00;
  // Both sensed phases follow the mains together
  assign sense_a = supply_on;
  assign sense_b = supply_on;
  // Lock drops with the mains and needs settling time to return
  always_ff @(posedge clk) begin
    if (!supply_on) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'(LOCK_CYC)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign lock = cnt_q == 8'(LOCK_CYC);
endmodule
`default_nettype wire

// [testbench/mdtm_trip_monitor_asserts.sv]
// Port checks for the motor drive trip monitor
`timescale 1ns/1ns
`default_nettype none
module mdtm_trip_monitor_asserts #(
  parameter int TICK_DIV = 4 // Clocks per ms
) (
  input wire logic CORE_CLK, // Clock
  input wire logic RESET, // Reset
  input wire logic WB_CYC_I, // Cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_ACK_O, // Ack
  input wire logic USER_TRIP, // User trip
  input wire logic REFX_BAD, // Bad exchange
  input wire logic JOG, // Jog
  input wire logic SUPPLY_SENSE_A, // Phase A
  input wire logic SUPPLY_SENSE_B, // Phase B
  input wire logic CONTACTOR, // Contactor
  input wire logic CURRENT_EN, // Current on
  input wire logic FIELD_EN, // Field on
  input wire logic TRIP, // Tripped
  input wire logic [3:0] TRIP_CODE, // Trip code
  input wire logic REFX_WARN // Exchange warning
);
  import mdtm_pkg::*;
  // ----------
  // Helpers
  // ----------
  // Tick phase is unknown, so user trip timing is judged in clocks
  localparam int EARLY = 499 * TICK_DIV;
  localparam int LATE = 501 * TICK_DIV + 3;
  logic [31:0] user_cnt_q;
  // Clocks the user trip input has been held high
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !USER_TRIP) begin
      user_cnt_q <= 32'h0;
    end else begin
      user_cnt_q <= user_cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  // ----------
  // Properties
  // ----------
  sequence s_take; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_loss; (!SUPPLY_SENSE_A || !SUPPLY_SENSE_B) [*4]; endsequence
  property p_ack; s_take |=> WB_ACK_O; endproperty
  property p_ack_once; WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_off; TRIP [*3] |-> !CONTACTOR && !CURRENT_EN && !FIELD_EN;
  endproperty
  property p_code; TRIP && $past(TRIP) |-> $stable(TRIP_CODE); endproperty
  property p_refx; TRIP |-> TRIP_CODE != 4'(AL_REFX); endproperty
  property p_early;
    $rose(TRIP) && TRIP_CODE == 4'(AL_USER) |-> user_cnt_q >= EARLY;
  endproperty
  property p_late; user_cnt_q == LATE |-> TRIP; endproperty
  property p_cur; s_loss |-> !CURRENT_EN; endproperty
  property p_jog;
    $rose(JOG) && !REFX_BAD && !$past(REFX_BAD)
    ##1 !REFX_BAD [*2] |-> ##[0:2] !REFX_WARN;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_off: assert property (p_off) else $error("power on in trip");
  a_code: assert property (p_code) else $error("code moved");
  a_refx: assert property (p_refx) else $error("exchange tripped");
  a_early: assert property (p_early) else $error("user trip early");
  a_late: assert property (p_late) else $error("user trip late");
  a_cur: assert property (p_cur) else $error("current in loss");
  a_jog: assert property (p_jog) else $error("warn kept");
endmodule
bind mdtm_trip_monitor mdtm_trip_monitor_asserts #(
  .TICK_DIV(TICK_DIV)
) u_mdtm_trip_monitor_asserts (
  .CORE_CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .USER_TRIP,
  .REFX_BAD, .JOG, .SUPPLY_SENSE_A, .SUPPLY_SENSE_B, .CONTACTOR,
  .CURRENT_EN, .FIELD_EN, .TRIP, .TRIP_CODE, .REFX_WARN
);
`default_nettype wire

// [testbench/mdtm_trip_monitor_bench.sv]
// Self-checking bench for the motor drive trip monitor
`timescale 1ns/1ns
`default_nettype none
module mdtm_trip_monitor_bench;
  import mdtm_pkg::*;
  localparam int TD = 4; // Short tick: one ms is four clocks
  logic CORE_CLK = 1'h0, RESET = 1'h1, supply_on = 1'h1;
  logic WB_CYC_I = 1'h0, WB_STB_I = 1'h0, WB_WE_I = 1'h0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
  logic [15:0] ARM_VOLT_FB = 16'h0, FIELD_CUR_FB = 16'h0, SPEED_FB = 16'h0;
  logic [15:0] THERM_OHMS_FB = 16'h00c8;
  logic FIELD_LOSS = 1'h0, USER_TRIP = 1'h0, REFX_BAD = 1'h0, JOG = 1'h0;
  logic ARMATURE_VOLTAGE_SPEED_FEEDBACK = 1'h0, FIELD_WEAKEN = 1'h0;
  logic START = 1'h0, RUN = 1'h1, COAST_STOP = 1'h1, HEATSINK_CLOSED = 1'h1;
  logic SUPPLY_SENSE_A, SUPPLY_SENSE_B, SYNC_LOCK, WB_ACK_O, CONTACTOR;
  logic CURRENT_EN, FIELD_EN, TRIP, THERM_WARN, REFX_WARN, AT_ERROR, AT_QUIT;
  logic [3:0] TRIP_CODE;
  logic [7:0] ra [4] = '{REG_CTRL, REG_OVD, REG_VMAX, 8'h1c};
  logic [31:0] rv [4] = '{32'h1, 32'h32, 32'hffff, 32'h0};
  int miscompares = 0, checks_done = 0;
  always #2 CORE_CLK = ~CORE_CLK;
  mdtm_sensor_model u_mdtm_sensor_model (
    .clk(CORE_CLK), .supply_on, .sense_a(SUPPLY_SENSE_A),
    .sense_b(SUPPLY_SENSE_B), .lock(SYNC_LOCK)
  );
  mdtm_trip_monitor #(.TICK_DIV(TD)) u_mdtm_trip_monitor (
    .CORE_CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .ARM_VOLT_FB,
    .FIELD_CUR_FB, .SPEED_FB, .THERM_OHMS_FB, .FIELD_LOSS, .USER_TRIP,
    .HEATSINK_CLOSED, .SUPPLY_SENSE_A, .SUPPLY_SENSE_B, .SYNC_LOCK,
    .ARMATURE_VOLTAGE_SPEED_FEEDBACK, .FIELD_WEAKEN, .REFX_BAD, .START,
    .JOG, .RUN, .COAST_STOP, .CONTACTOR, .CURRENT_EN, .FIELD_EN, .TRIP,
    .TRIP_CODE, .THERM_WARN, .REFX_WARN, .AT_ERROR, .AT_QUIT
  );
  // ----------
  // Tasks
  // ----------
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tk(input int ms);
    repeat (ms * TD) @(posedge CORE_CLK);
  endtask
  // One classic cycle; the bound stops a missing ack from hanging
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge CORE_CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_SEL_I} <= {2'h3, we, 4'hf};
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(posedge CORE_CLK);
    while (WB_ACK_O !== 1'h1 && n < 20) begin
      @(posedge CORE_CLK);
      n++;
    end
    rd = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
    if (n == 20) begin
      miscompares++;
      complete_run();
    end
  endtask
  // A fresh start edge clears a trip, or starts the drive if none
  task automatic restart;
    {USER_TRIP, FIELD_WEAKEN, ARM_VOLT_FB, SPEED_FB} <= 34'h0;
    START <= 1'h0;
    tk(1);
    START <= 1'h1;
    tk(1);
  endtask
  // Trip must stay off just short of the delay and be up just after it
  task automatic trip_case(input int ms, input int code);
    tk(ms - 2);
    chk(TRIP, 1'h0, "early");
    tk(4);
    chk(TRIP, 1'h1, "trip");
    chk(TRIP_CODE, code, "code");
    restart();
  endtask
  // ----------
  // Scenarios
  // ----------
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      wb(1'h0, ra[i], 32'h0);
      chk(rd, rv[i], "reg");
    end
    wb(1'h1, REG_OVD, 32'h2000);
    wb(1'h0, REG_OVD, 32'h0);
    chk(rd, 32'h1770, "ovd");
    wb(1'h1, REG_OVD, 32'h0);
    wb(1'h1, REG_VMAX, 32'h64);
    wb(1'h1, REG_SPD_RATED, 32'h64);
    restart();
    chk({CURRENT_EN, FIELD_EN}, 2'h3, "run");
    supply_on <= 1'h0;
    tk(1000);
    chk(CONTACTOR, 1'h1, "ride");
    chk(CURRENT_EN, 1'h0, "nocur");
    supply_on <= 1'h1;
    tk(2);
    chk(CURRENT_EN, 1'h1, "resume");
    USER_TRIP <= 1'h1;
    tk(400);
    USER_TRIP <= 1'h0;
    tk(1);
    USER_TRIP <= 1'h1;
    tk(498);
    chk(TRIP, 1'h0, "user");
    chk(CONTACTOR, 1'h1, "cont");
    trip_case(2, AL_USER);
    chk(TRIP, 1'h0, "clear");
    ARMATURE_VOLTAGE_SPEED_FEEDBACK <= 1'h1;
    FIELD_WEAKEN <= 1'h1;
    trip_case(2, AL_SPDMIS);
    ARM_VOLT_FB <= 16'h0078;
    tk(1600);
    chk(TRIP, 1'h0, "aov");
    ARM_VOLT_FB <= 16'h0079;
    trip_case(1500, AL_AOV);
    SPEED_FB <= 16'h006f;
    trip_case(600, AL_OVSPD);
    HEATSINK_CLOSED <= 1'h0;
    trip_case(750, AL_HEAT);
    chk(TRIP, 1'h1, "hot");
    HEATSINK_CLOSED <= 1'h1;
    restart();
    chk(TRIP, 1'h0, "cool");
    REFX_BAD <= 1'h1;
    tk(1504);
    chk({TRIP, REFX_WARN}, 2'h1, "refx");
    REFX_BAD <= 1'h0;
    tk(1);
    JOG <= 1'h1;
    tk(1);
    chk(REFX_WARN, 1'h0, "jog");
    complete_run();
  end
endmodule
`default_nettype wire
